// ===== rtl/irq_vec_pkg.sv
// Constants and carrier types for the interrupt gate and vector encoder.
// Assumes a single core clock and synchronous active-low core reset.
package irq_vec_pkg;

  localparam int          MAX_IRQ      = 32;
  localparam logic [5:0]  OPC_CUSTOM   = 6'h32;
  localparam int          OPC_LSB      = 0;
  localparam int          SEL_LSB      = 6;
  localparam int          WRC_POS      = 14;
  localparam int          RDB_POS      = 15;
  localparam int          RDA_POS      = 16;
  localparam int          DST_LSB      = 17;
  localparam int          SRCB_LSB     = 22;
  localparam int          SRCA_LSB     = 27;
  localparam int          VEC_SHIFT    = 3;
  localparam logic [31:0] VEC_NEGATIVE = 32'hffff_ffff;
  localparam logic        GIE_RESET    = 1'b0;
  localparam logic [31:0] EXC_ADDR_DEF = 32'h0000_0020;
  localparam logic [7:0]  SEL_DEF      = 8'h00;
  localparam int          SYNC_STAGES  = 2;

  // Custom instruction issue from the core
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
  } ci_req_t;

  // Custom instruction answer to the core
  typedef struct packed {
    logic        done;
    logic [4:0]  dest;
    logic [31:0] result;
  } ci_rsp_t;

endpackage : irq_vec_pkg

// ===== rtl/irq_gate_and_vector_encoder.sv
// Interrupt gate, global enable with save/restore, and vector instruction.
// Assumes the core pulses exc_entry on taking any exception and eret on return.
`timescale 1ns/1ps
module irq_gate_and_vector_encoder
  import irq_vec_pkg::*;
#(
  parameter int          NUM_IRQ  = MAX_IRQ,
  parameter logic [31:0] EXC_ADDR = EXC_ADDR_DEF,
  parameter logic [7:0]  VEC_SEL  = SEL_DEF
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  // Request pins from peripherals
  input  wire logic [NUM_IRQ-1:0] irq_req,
  // Enable mask and global enable control
  input  wire logic               mask_wr,
  input  wire logic [NUM_IRQ-1:0] mask_wr_data,
  input  wire logic               gie_wr,
  input  wire logic               gie_wr_data,
  // Exception sequencing from the core
  input  wire logic               exc_entry,
  input  wire logic               eret,
  // Vector instruction port
  input  wire ci_req_t            ci_req,
  output      ci_rsp_t            ci_rsp,
  // Status towards the core
  output      logic               irq_take,
  output      logic [31:0]        exc_addr,
  output      logic [NUM_IRQ-1:0] irq_pending,
  output      logic [NUM_IRQ-1:0] irq_mask,
  output      logic               global_irq_enable,
  output      logic               saved_irq_enable
);

  logic [NUM_IRQ-1:0] sync1_r;
  logic [NUM_IRQ-1:0] sync2_r;
  logic [NUM_IRQ-1:0] mask_r;
  logic               gie_r;
  logic               gie_nxt;
  logic               saved_r;
  logic               saved_nxt;
  ci_rsp_t            rsp_r;
  ci_rsp_t            rsp_nxt;
  logic [4:0]         win_idx;
  logic               any_pend;
  logic               ci_hit;
  logic [31:0]        vec_val;

  // two-flop input sync
  // Each line is a level, so a plain double flop is enough
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= irq_req;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mask_r <= '0;
    end else if (mask_wr) begin
      mask_r <= mask_wr_data;
    end
  end

  assign irq_pending = sync2_r & mask_r;
  assign any_pend    = |irq_pending;

  // plain OR, no ordering among sources
  assign irq_take = gie_r & any_pend;

  assign exc_addr = EXC_ADDR;

  // entry saves and clears; software may set it again to nest
  // Entry wins over eret and writes so a nested take never loses its save
  always_comb begin
    gie_nxt   = gie_r;
    saved_nxt = saved_r;
    if (exc_entry) begin
      saved_nxt = gie_r;
      gie_nxt   = 1'b0;
    end else if (eret) begin
      gie_nxt = saved_r;
    end else if (gie_wr) begin
      gie_nxt = gie_wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      gie_r   <= GIE_RESET;
      saved_r <= GIE_RESET;
    end else begin
      gie_r   <= gie_nxt;
      saved_r <= saved_nxt;
    end
  end

  assign global_irq_enable = gie_r;
  assign saved_irq_enable  = saved_r;
  assign irq_mask          = mask_r;

  assign ci_hit = ci_req.valid
                & (ci_req.instr[OPC_LSB +: 6] == OPC_CUSTOM)
                & (ci_req.instr[SRCA_LSB +: 5] == 5'h00)
                & (ci_req.instr[SRCB_LSB +: 5] == 5'h00)
                & !ci_req.instr[RDA_POS]
                & !ci_req.instr[RDB_POS]
                & ci_req.instr[WRC_POS]
                & (ci_req.instr[SEL_LSB +: 8] == VEC_SEL);

  // lowest index wins, scanned from the top down
  always_comb begin
    win_idx = 5'h00;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_pending[i]) begin
        win_idx = 5'(i);
      end
    end
  end

  // negative when idle or saved enable clear
  assign vec_val = (!any_pend || !saved_r) ? VEC_NEGATIVE
                 : {24'h00_0000, win_idx, 3'h0};

  // One-cycle answer, result held in a flop for timing
  always_comb begin
    rsp_nxt        = rsp_r;
    rsp_nxt.done   = ci_hit;
    if (ci_hit) begin
      rsp_nxt.dest   = ci_req.instr[DST_LSB +: 5];
      rsp_nxt.result = vec_val;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  assign ci_rsp = rsp_r;

  // Helper: lowest-set check of the returned index
  logic [NUM_IRQ-1:0] pend_q;
  logic [4:0]         res_idx;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= irq_pending;
    end
  end
  assign res_idx = rsp_r.result[VEC_SHIFT +: 5];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_entry;
    exc_entry;
  endsequence

  sequence s_eret_only;
    eret && !exc_entry;
  endsequence

  a_take_needs_all: assert property (
    irq_take |-> gie_r && |(sync2_r & mask_r))
    else $error("interrupt taken without enable, request and mask");

  a_masked_line_quiet: assert property (
    (mask_r == '0) |-> !irq_take)
    else $error("interrupt taken with all sources masked");

  a_req_to_take: assert property (
    gie_r && |($past(irq_req, 2) & mask_r) |-> irq_take)
    else $error("enabled request not taken after two-cycle sync");

  a_entry_saves_gie: assert property (
    s_entry |=> !gie_r && (saved_r == $past(gie_r)))
    else $error("exception entry did not save and clear global enable");

  a_eret_restores: assert property (
    s_eret_only |=> gie_r == $past(saved_r))
    else $error("return did not restore global enable");

  a_mask_write: assert property (
    mask_wr |=> mask_r == $past(mask_wr_data))
    else $error("mask write not stored");

  a_vec_negative: assert property (
    ci_hit && (!any_pend || !saved_r) |=> rsp_r.done && rsp_r.result[31])
    else $error("vector not negative with nothing pending");

  a_vec_lowest: assert property (
    ci_hit && any_pend && saved_r |=> rsp_r.done && !rsp_r.result[31]
      && (rsp_r.result[2:0] == 3'h0) && pend_q[res_idx]
      && ((pend_q & ((NUM_IRQ'(1) << res_idx) - NUM_IRQ'(1))) == '0))
    else $error("vector is not eight times lowest pending index");

  a_ci_decode: assert property (
    ci_req.valid && (ci_req.instr[5:0] != OPC_CUSTOM) |=> !rsp_r.done)
    else $error("foreign opcode answered");

  a_exc_addr_fixed: assert property (
    exc_addr == EXC_ADDR)
    else $error("exception address changed");

endmodule : irq_gate_and_vector_encoder

// ===== tb/irq_src_model.sv
// Peripheral request sources as seen by the interrupt gate.
// Assumes the bench raises and clears lines just after a falling edge.
`timescale 1ns/1ps
module irq_src_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Raise and clear commands from handler software
  input  wire logic [31:0] raise,
  input  wire logic [31:0] clr,
  // One level request pin per source
  output      logic [31:0] irq_req
);
  always_ff @(posedge clk_sys) begin
    if (!resetn) irq_req <= '0;
    else irq_req <= (irq_req & ~clr) | raise;
  end
endmodule : irq_src_model

// ===== tb/testbench.sv
// Random and corner checks of the interrupt gate and vector encoder.
// Assumes default parameters and the source model in front of it.
`timescale 1ns/1ps
module testbench;
  import irq_vec_pkg::*;
  logic        clk_sys = 0;
  logic        resetn = 0;
  logic [31:0] raise, clr, mask_wr_data, irq_req, exc_addr, pend, msk;
  logic        mask_wr, gie_wr, gie_wr_data, exc_entry, eret, take, gie, sgie;
  ci_req_t     ci_req;
  ci_rsp_t     ci_rsp;
  int          n_errors = 0;
  int          checked = 0;
  logic [31:0] st = 32'h55;
  always #5 clk_sys = ~clk_sys;
  irq_src_model irq_src_model_i (.clk_sys(clk_sys), .resetn(resetn),
    .raise(raise), .clr(clr), .irq_req(irq_req));
  irq_gate_and_vector_encoder irq_gate_and_vector_encoder_i (
    .clk_sys(clk_sys), .resetn(resetn), .irq_req(irq_req), .mask_wr(mask_wr),
    .mask_wr_data(mask_wr_data), .gie_wr(gie_wr), .gie_wr_data(gie_wr_data),
    .exc_entry(exc_entry), .eret(eret), .ci_req(ci_req), .ci_rsp(ci_rsp),
    .irq_take(take), .exc_addr(exc_addr), .irq_pending(pend), .irq_mask(msk),
    .global_irq_enable(gie), .saved_irq_enable(sgie));
  // Value compare, four-state exact
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  function logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : xs
  // Expected vector: lowest pending line wins
  function logic [31:0] exp_vec(input logic [31:0] p, input logic s);
    if (!s || p == 0) return 32'hffff_ffff;
    for (int i = 0; i < 32; i++) if (p[i]) return 32'(i * 8);
    return 32'hffff_ffff;
  endfunction : exp_vec
  // Levels, mask and enable in one go, then wait out the synchroniser
  task set_state(input logic [31:0] r, input logic [31:0] m, input logic g);
    {raise, clr, mask_wr, mask_wr_data, gie_wr, gie_wr_data} = {r, ~32'h0, 1'b1, m, 1'b1, g};
    @(negedge clk_sys);
    {raise, clr, mask_wr, gie_wr} = '0;
    repeat (2) @(negedge clk_sys);
  endtask : set_state
  // Issue one word; answer is due one cycle later, then one idle cycle
  // The idle cycle keeps two calls from driving ci_req twice in one step
  task vec(input logic [31:0] w, input logic dn, input logic [31:0] exp);
    ci_req = {1'b1, w};
    @(negedge clk_sys);
    ci_req = '0;
    cmp({31'h0, ci_rsp.done}, {31'h0, dn});
    cmp({27'h0, ci_rsp.dest}, {27'h0, w[21:17]});
    cmp(ci_rsp.result, exp);
    @(negedge clk_sys);
    cmp({31'h0, ci_rsp.done}, 32'h0);
  endtask : vec
  task final_report;
    $display("mismatches %0d of %0d compares", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end
  initial begin
    logic [31:0] r, m, w;
    logic        g;
    {raise, clr, mask_wr, mask_wr_data, gie_wr, gie_wr_data, exc_entry, eret} = '0;
    ci_req = '0;
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
    cmp(msk, '0);
    cmp({30'h0, gie, take}, '0);
    cmp(exc_addr, EXC_ADDR_DEF);
    for (int i = 0; i < 40; i++) begin
      r = xs();
      m = xs();
      g = i[0] | r[7];
      if (i == 1) r = 32'h0;
      if (i == 2) {r, m} = {32'h8000_0000, ~32'h0};
      if (i == 4) {r, m} = {~32'h0, ~32'h0};
      set_state(r, m, g);
      cmp(msk, m);
      cmp(pend, r & m);
      cmp({31'h0, take}, {31'h0, g & |(r & m)});
      exc_entry = 1'b1;
      @(negedge clk_sys);
      exc_entry = 1'b0;
      cmp({30'h0, gie, take}, '0);
      cmp(exc_addr, EXC_ADDR_DEF);
      cmp({31'h0, sgie}, {31'h0, g});
      w = {10'h0, 5'(i), 3'b001, SEL_DEF, OPC_CUSTOM};
      // vector issued only inside the handler
      vec(w, 1'b1, exp_vec(r & m, g));
      vec(w ^ 32'h1, 1'b0, exp_vec(r & m, g));
      vec(w | 32'h0800_0000, 1'b0, exp_vec(r & m, g));
      {gie_wr, gie_wr_data} = 2'b11;
      @(negedge clk_sys);
      gie_wr = 1'b0;
      cmp({31'h0, take}, {31'h0, |(r & m)});
      eret = 1'b1;
      @(negedge clk_sys);
      eret = 1'b0;
      cmp({31'h0, gie}, {31'h0, g});
    end
    final_report();
  end
endmodule : testbench
